// ### ibm_defines.vh
// Purpose: Shared constants of the two-wire byte master block
// Assumes: 32-bit APB data, registers in the low byte of a word
// Notes:   Byte address of a register is four times its index
`ifndef IBM_DEFINES_VH
`define IBM_DEFINES_VH

// Register indices and byte addresses
`define IBM_IDX_CTRL        12'h0_0e1
`define IBM_IDX_DATA        12'h0_0e2
`define IBM_IDX_IRQ_STAT    12'h0_0e3
`define IBM_IDX_IRQ_MASK    12'h0_0e4
`define IBM_ADDR_CTRL       12'h3_84
`define IBM_ADDR_DATA       12'h3_88
`define IBM_ADDR_IRQ_STAT   12'h3_8c
`define IBM_ADDR_IRQ_MASK   12'h3_90

// Control register fields
`define IBM_CTL_ENABLE      7
`define IBM_CTL_ACK_SEL     6
`define IBM_CTL_DONE        5
`define IBM_CTL_ACK_IN      4
`define IBM_CTL_START       3
`define IBM_CTL_STOP        2
`define IBM_CTL_CLK_HI      1
`define IBM_CTL_CLK_LO      0

// Interrupt status and mask fields
`define IBM_IRQ_DONE        0
`define IBM_IRQ_NACK        1
`define IBM_IRQ_W           2

// Reset values
`define IBM_RST_STOP        1'b1
`define IBM_RST_CLK_SEL     2'h0
`define IBM_RST_DATA        8'h00
`define IBM_RST_MASK        2'h0

// Clock select codes
`define IBM_CLK_DIV4        2'h0
`define IBM_CLK_DIV16       2'h1
`define IBM_CLK_DIV64       2'h2
`define IBM_CLK_DIV256      2'h3

// Quarter-period lengths in system clocks for each code; DIV256 holds its last count, 63
`define IBM_QTR_DIV4        6'h01
`define IBM_QTR_DIV16       6'h04
`define IBM_QTR_DIV64       6'h10
`define IBM_QTR_DIV256      6'h3f

// Bit counter value of the acknowledge slot, after the eight data bits
`define IBM_ACK_SLOT        4'h8

`endif

// ### ibm_sync.v
// Purpose: Two-flop synchroniser for the sampled bus lines
// Assumes: Inputs are asynchronous to pclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ibm_sync #(
    parameter WIDTH = 2
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_ff;
            reg sync_ff;
            // Lines idle high, so reset to one
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                end else begin
                    meta_ff <= async_in[i];
                    sync_ff <= meta_ff;
                end
            end
            assign sync_out[i] = sync_ff;
        end
    endgenerate

endmodule // ibm_sync

// ### ibm_clkdiv.v
// Purpose: Quarter-period enable pulse for the serial clock
// Assumes: Select code is stable while a byte is on the bus
// Notes:   Serial clock period is four pulses
`timescale 1ns/1ps
`include "ibm_defines.vh"
module ibm_clkdiv (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    input  wire [1:0] clk_sel,
    output reg        tick_ff
);

    reg  [5:0] cnt_ff;
    reg  [5:0] qtr_len;

    // Codes 00 and 01 are served anyway; software must avoid them
    always @* begin
        case (clk_sel)
            `IBM_CLK_DIV4:  qtr_len = `IBM_QTR_DIV4;
            `IBM_CLK_DIV16: qtr_len = `IBM_QTR_DIV16;
            `IBM_CLK_DIV64: qtr_len = `IBM_QTR_DIV64;
            default:        qtr_len = `IBM_QTR_DIV256;
        endcase
    end

    // Divide by 256 needs 64 clocks per quarter, so count 0..63
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= 6'h00;
            tick_ff <= 1'b0;
        end else if (!run) begin
            cnt_ff  <= 6'h00;
            tick_ff <= 1'b0;
        end else if ((clk_sel == `IBM_CLK_DIV256) ? (cnt_ff == qtr_len)
                                                  : (cnt_ff == qtr_len - 6'h01)) begin
            cnt_ff  <= 6'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 6'h01;
            tick_ff <= 1'b0;
        end
    end

endmodule // ibm_clkdiv

// ### ibm_master.v
// Purpose: Two-wire bus byte master with APB register access
// Assumes: pclk at 200 MHz, bus lines open drain with pull-ups
// Notes:   APB access takes one wait state; pready is registered
`timescale 1ns/1ps
`include "ibm_defines.vh"

// Contract
// - Master runs only while enable bit 7 is one; resets to zero.
// - Receive acknowledge comes from bit 6: zero sends ACK, one NACK.
// - Bit 5 sets when a byte completes; software writes zero to clear.
// - Bit 4 holds the slave acknowledge of a transmit: zero ACK, one NACK.
// - Writing one to bit 3 issues a start condition; bit resets to zero.
// - Writing one to bit 2 issues a stop condition; bit resets to one.
// - Clock select 10 gives system clock over 64, 11 over 256.
// - Data write between start and stop loads and transmits the byte.
// - Data read between start and stop returns the byte and receives next.
module ibm_master (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    output reg         irq_ff,
    input  wire        scl_i,
    output reg         scl_o_ff,
    output reg         scl_oe_ff,
    input  wire        sda_i,
    output reg         sda_o_ff,
    output reg         sda_oe_ff
);

    // Bus states
    localparam ST_IDLE  = 3'b000;
    localparam ST_START = 3'b001;
    localparam ST_HOLD  = 3'b010;
    localparam ST_XFER  = 3'b011;
    localparam ST_STOP  = 3'b100;

    reg  [2:0]  st_ff;
    reg  [1:0]  phase_ff;
    reg  [3:0]  bit_ff;
    reg         rx_ff;
    reg  [7:0]  shift_ff;
    reg         enable_ff;
    reg         ack_sel_ff;
    reg         done_ff;
    reg         ack_in_ff;
    reg         start_ff;
    reg         stop_ff;
    reg  [1:0]  clk_sel_ff;
    reg  [1:0]  irq_stat_ff;
    reg  [1:0]  irq_mask_ff;
    reg         go_tx_ff;
    reg         go_rx_ff;
    reg         go_stop_ff;
    wire        tick;
    wire [1:0]  line_s;
    wire        scl_s;
    wire        sda_s;
    wire        acc_done;
    wire        wr_ctrl;
    wire        wr_data;
    wire        rd_data;
    wire        rd_stat;
    wire        wr_mask;
    wire        mapped;
    wire        byte_done;
    wire        tx_nack;
    wire [7:0]  ctrl_view;

    // Bus lines pass two flops before any use
    ibm_sync #(.WIDTH(2)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({scl_i, sda_i}),
        .sync_out (line_s)
    );
    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    // Divider idles while disabled so no stale pulse starts a frame
    ibm_clkdiv u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (enable_ff),
        .clk_sel  (clk_sel_ff),
        .tick_ff  (tick)
    );

    // APB decode; side effects land on the completing edge only
    assign acc_done = psel & penable & pready_ff;
    assign mapped   = (paddr == `IBM_ADDR_CTRL) || (paddr == `IBM_ADDR_DATA) ||
                      (paddr == `IBM_ADDR_IRQ_STAT) || (paddr == `IBM_ADDR_IRQ_MASK);
    assign wr_ctrl  = acc_done & pwrite & (paddr == `IBM_ADDR_CTRL);
    assign wr_data  = acc_done & pwrite & (paddr == `IBM_ADDR_DATA);
    assign rd_data  = acc_done & ~pwrite & (paddr == `IBM_ADDR_DATA);
    assign rd_stat  = acc_done & ~pwrite & (paddr == `IBM_ADDR_IRQ_STAT);
    assign wr_mask  = acc_done & pwrite & (paddr == `IBM_ADDR_IRQ_MASK);

    // Byte ends on the falling edge after the acknowledge clock
    assign byte_done = tick & (st_ff == ST_XFER) & (phase_ff == 2'h3) &
                       (bit_ff == `IBM_ACK_SLOT);
    assign tx_nack   = byte_done & ~rx_ff & ack_in_ff;
    assign ctrl_view = {enable_ff, ack_sel_ff, done_ff, ack_in_ff,
                        start_ff, stop_ff, clk_sel_ff};

    // APB answer: one wait state, data captured on the edge that raises pready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (psel & penable & ~pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= ~mapped;
            if (pwrite || !mapped) begin
                prdata_ff <= 32'h0000_0000;
            end else if (paddr == `IBM_ADDR_CTRL) begin
                prdata_ff <= {24'h00_0000, ctrl_view};
            end else if (paddr == `IBM_ADDR_DATA) begin
                prdata_ff <= {24'h00_0000, shift_ff};
            end else if (paddr == `IBM_ADDR_IRQ_STAT) begin
                prdata_ff <= {30'h0000_0000, irq_stat_ff};
            end else begin
                prdata_ff <= {30'h0000_0000, irq_mask_ff};
            end
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // Control register; hardware set of the done flag beats a clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff  <= 1'b0;
            ack_sel_ff <= 1'b0;
            done_ff    <= 1'b0;
            stop_ff    <= `IBM_RST_STOP;
            clk_sel_ff <= `IBM_RST_CLK_SEL;
        end else begin
            if (wr_ctrl) begin
                enable_ff  <= pwdata[`IBM_CTL_ENABLE];
                ack_sel_ff <= pwdata[`IBM_CTL_ACK_SEL];
                stop_ff    <= pwdata[`IBM_CTL_STOP];
                clk_sel_ff <= pwdata[`IBM_CTL_CLK_HI:`IBM_CTL_CLK_LO];
            end
            if (byte_done) begin
                done_ff <= 1'b1;
            end else if (wr_ctrl && !pwdata[`IBM_CTL_DONE]) begin
                done_ff <= 1'b0;
            end
        end
    end

    // Start bit stays up until the start condition is on the bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_ff <= 1'b0;
        end else if (!enable_ff) begin
            start_ff <= 1'b0;
        end else if (tick && st_ff == ST_START && phase_ff == 2'h3) begin
            start_ff <= 1'b0;
        end else if (wr_ctrl) begin
            start_ff <= pwdata[`IBM_CTL_START];
        end
    end

    // Requests from data and stop accesses, served when parked
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_tx_ff   <= 1'b0;
            go_rx_ff   <= 1'b0;
            go_stop_ff <= 1'b0;
        end else if (!enable_ff || st_ff != ST_HOLD) begin
            go_tx_ff   <= 1'b0;
            go_rx_ff   <= 1'b0;
            go_stop_ff <= 1'b0;
        end else begin
            if (wr_data) begin
                go_tx_ff <= 1'b1;
            end
            if (rd_data) begin
                go_rx_ff <= 1'b1;
            end
            if (wr_ctrl && pwdata[`IBM_CTL_STOP]) begin
                go_stop_ff <= 1'b1;
            end
        end
    end

    // Interrupt status is cleared by reading it; a new event wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= `IBM_RST_MASK;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff[`IBM_IRQ_DONE] <= byte_done |
                                          (irq_stat_ff[`IBM_IRQ_DONE] & ~rd_stat);
            irq_stat_ff[`IBM_IRQ_NACK] <= tx_nack |
                                          (irq_stat_ff[`IBM_IRQ_NACK] & ~rd_stat);
            if (wr_mask) begin
                irq_mask_ff <= pwdata[`IBM_IRQ_W-1:0];
            end
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Bus sequencer; each step waits for a quarter-period pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff     <= ST_IDLE;
            phase_ff  <= 2'h0;
            bit_ff    <= 4'h0;
            rx_ff     <= 1'b0;
            shift_ff  <= `IBM_RST_DATA;
            ack_in_ff <= 1'b0;
            scl_o_ff  <= 1'b0;
            sda_o_ff  <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (!enable_ff) begin
            // Disabled master lets go of both lines at once
            st_ff     <= ST_IDLE;
            phase_ff  <= 2'h0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            if (wr_data) begin
                shift_ff <= pwdata[7:0];
            end
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    phase_ff <= 2'h0;
                    if (wr_data) begin
                        shift_ff <= pwdata[7:0];
                    end
                    if (start_ff) begin
                        st_ff <= ST_START;
                    end
                end
                ST_HOLD: begin
                    phase_ff <= 2'h0;
                    bit_ff   <= 4'h0;
                    if (wr_data) begin
                        shift_ff <= pwdata[7:0];
                    end
                    // Stop beats a pending start, a start beats data
                    if (go_stop_ff) begin
                        st_ff <= ST_STOP;
                    end else if (start_ff) begin
                        st_ff <= ST_START;
                    end else if (go_tx_ff) begin
                        st_ff <= ST_XFER;
                        rx_ff <= 1'b0;
                    end else if (go_rx_ff) begin
                        st_ff <= ST_XFER;
                        rx_ff <= 1'b1;
                    end
                end
                ST_START: begin
                    // Release both, then pull data low under a high clock
                    if (tick) begin
                        case (phase_ff)
                            2'h0: begin
                                sda_oe_ff <= 1'b0;
                                phase_ff  <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe_ff <= 1'b0;
                                phase_ff  <= 2'h2;
                            end
                            2'h2: begin
                                if (scl_s) begin
                                    sda_oe_ff <= 1'b1;
                                    phase_ff  <= 2'h3;
                                end
                            end
                            default: begin
                                scl_oe_ff <= 1'b1;
                                phase_ff  <= 2'h0;
                                st_ff     <= ST_HOLD;
                            end
                        endcase
                    end
                end
                ST_XFER: begin
                    // Eight data clocks, then the acknowledge clock
                    if (tick) begin
                        case (phase_ff)
                            2'h0: begin
                                if (bit_ff == `IBM_ACK_SLOT) begin
                                    sda_oe_ff <= rx_ff & ~ack_sel_ff;
                                end else begin
                                    sda_oe_ff <= ~rx_ff & ~shift_ff[7];
                                end
                                phase_ff <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe_ff <= 1'b0;
                                phase_ff  <= 2'h2;
                            end
                            2'h2: begin
                                // A slave holding the clock low stretches it
                                if (scl_s) begin
                                    if (bit_ff == `IBM_ACK_SLOT) begin
                                        if (!rx_ff) begin
                                            ack_in_ff <= sda_s;
                                        end
                                    end else begin
                                        shift_ff <= {shift_ff[6:0], sda_s};
                                    end
                                    phase_ff <= 2'h3;
                                end
                            end
                            default: begin
                                scl_oe_ff <= 1'b1;
                                phase_ff  <= 2'h0;
                                if (bit_ff == `IBM_ACK_SLOT) begin
                                    sda_oe_ff <= 1'b0;
                                    st_ff     <= ST_HOLD;
                                end else begin
                                    bit_ff <= bit_ff + 4'h1;
                                end
                            end
                        endcase
                    end
                end
                ST_STOP: begin
                    // Data rises while the clock is high
                    if (tick) begin
                        case (phase_ff)
                            2'h0: begin
                                sda_oe_ff <= 1'b1;
                                phase_ff  <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe_ff <= 1'b0;
                                phase_ff  <= 2'h2;
                            end
                            2'h2: begin
                                if (scl_s) begin
                                    sda_oe_ff <= 1'b0;
                                    phase_ff  <= 2'h3;
                                end
                            end
                            default: begin
                                phase_ff <= 2'h0;
                                st_ff    <= ST_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    st_ff    <= ST_IDLE;
                    phase_ff <= 2'h0;
                end
            endcase
        end
    end

endmodule // ibm_master

// ### ibm_bus_slave.sv
// Purpose: Behavioural two-wire slave on the far side of the byte master
// Assumes: Lines are wired-AND with pull-ups
// Notes:   Drive changes only on falling scl, never while scl is high
`timescale 1ns/1ps
module ibm_bus_slave (
    input  wire       scl,
    input  wire       sda,
    input  wire       nack,
    input  wire       rd,
    input  wire [7:0] rd_byte,
    input  wire       stretch,
    output wire       sda_pull,
    output reg        scl_pull,
    output reg  [8:0] rx
);
    integer bit_idx;
    initial begin
        bit_idx = -1;
        scl_pull = 1'b0;
        rx = 9'h000;
    end
    // Start or stop: sda moves while scl is high, frame counter restarts
    always @(negedge sda) if (scl) bit_idx = -1;
    always @(posedge sda) if (scl) bit_idx = -1;
    // Count on falling scl; stretch longer than the master low phase
    always @(negedge scl) begin
        bit_idx = (bit_idx == 8) ? 0 : bit_idx + 1;
        if (stretch) begin
            scl_pull = 1'b1;
            #200 scl_pull = 1'b0;
        end
    end
    // Nine bits per byte: data then acknowledge
    always @(posedge scl) if (bit_idx >= 0) rx = {rx[7:0], sda};
    // Released line shows the pull-up level, never a stale value
    assign sda_pull = (bit_idx >= 0) && (rd ? (bit_idx < 8 && !rd_byte[7 - bit_idx])
                                            : (bit_idx == 8 && !nack));
endmodule // ibm_bus_slave

// ### ibm_master_sva.sv
// Purpose: Port-level checks of the two-wire byte master
// Assumes: One pclk domain, presetn active low
// Notes:   Bound to every ibm_master instance
`timescale 1ns/1ps
`include "ibm_defines.vh"
module ibm_master_sva (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata_ff,
    input wire        pready_ff,
    input wire        pslverr_ff,
    input wire        irq_ff,
    input wire        scl_i,
    input wire        scl_o_ff,
    input wire        scl_oe_ff,
    input wire        sda_i,
    input wire        sda_o_ff,
    input wire        sda_oe_ff
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed accesses of interest
    wire acc_done = psel && penable && pready_ff;
    wire ctrl_off = acc_done && pwrite && paddr == `IBM_ADDR_CTRL && !pwdata[`IBM_CTL_ENABLE];
    wire stat_rd  = acc_done && !pwrite && paddr == `IBM_ADDR_IRQ_STAT;

    a_drain_only: assert property (!scl_o_ff && !sda_o_ff)
        else $error("bus line driven high");
    a_one_wait: assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("access not answered after one wait state");
    a_err_map: assert property (pready_ff |-> pslverr_ff == !(paddr inside {`IBM_ADDR_CTRL,
        `IBM_ADDR_DATA, `IBM_ADDR_IRQ_STAT, `IBM_ADDR_IRQ_MASK}))
        else $error("error response does not match address map");
    a_read_narrow: assert property (pready_ff && !pwrite |-> prdata_ff[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    a_off_release: assert property (ctrl_off |-> ##[1:3] (!scl_oe_ff && !sda_oe_ff))
        else $error("lines not released after disable");
    a_start_low: assert property ($rose(sda_oe_ff) && !scl_oe_ff |-> ##[1:70] scl_oe_ff)
        else $error("start not followed by clock low");
    a_stop_idle: assert property ($fell(sda_oe_ff) && !scl_oe_ff |=> (!sda_oe_ff && !scl_oe_ff) [*3])
        else $error("lines not idle after stop");
    a_irq_clear: assert property (stat_rd |-> ##2 !irq_ff)
        else $error("interrupt stays after status read");
    c_start: cover property ($rose(sda_oe_ff) && !scl_oe_ff);
    c_irq: cover property ($rose(irq_ff));
    c_refused: cover property (pready_ff && pslverr_ff);
endmodule // ibm_master_sva
bind ibm_master ibm_master_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff),
    .scl_i(scl_i), .scl_o_ff(scl_o_ff), .scl_oe_ff(scl_oe_ff), .sda_i(sda_i),
    .sda_o_ff(sda_o_ff), .sda_oe_ff(sda_oe_ff));

// ### ibm_master_test.sv
// Purpose: Self-checking bench of the two-wire byte master
// Assumes: Slave model on the wired-AND lines
// Notes:   Only select codes 10 and 11 are programmed while enabled
`timescale 1ns/1ps
`include "ibm_defines.vh"
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module ibm_master_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata_ff, r;
    logic        pready_ff, pslverr_ff, irq_ff, scl_o_ff, scl_oe_ff, sda_o_ff, sda_oe_ff, err;
    logic        nack = 1'b0, rd = 1'b0, stretch = 1'b0;
    logic [7:0]  rd_byte = 8'h00;
    wire  [8:0]  rx;
    wire         scl_pull, sda_pull;
    int          mismatches = 0, n_checks = 0;
    realtime     t_last = 0, per = 0;
    // Wired-AND lines with pull-ups
    wire scl = ~(scl_oe_ff | scl_pull);
    wire sda = ~(sda_oe_ff | sda_pull);
    // 200 MHz clock and serial clock period meter
    always #2.5 pclk = ~pclk;
    always @(posedge scl) begin
        per = $realtime - t_last;
        t_last = $realtime;
    end
    ibm_master dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
        .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .irq_ff(irq_ff), .scl_i(scl),
        .scl_o_ff(scl_o_ff), .scl_oe_ff(scl_oe_ff), .sda_i(sda), .sda_o_ff(sda_o_ff),
        .sda_oe_ff(sda_oe_ff));
    ibm_bus_slave slave_u (.scl(scl), .sda(sda), .nack(nack), .rd(rd), .rd_byte(rd_byte),
        .stretch(stretch), .sda_pull(sda_pull), .scl_pull(scl_pull), .rx(rx));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer; an extra edge keeps back-to-back calls from double driving
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
        @(posedge pclk) penable <= 1'b1;
        for (n = 0; n < 20 && pready_ff !== 1'b1; n++) @(posedge pclk);
        if (pready_ff !== 1'b1) begin mismatches++; end_of_test(); end
        r = prdata_ff; err = pslverr_ff;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_ctrl(input int b, input logic v);
        for (int n = 0; n < 3000; n++) begin
            apb(1'b0, `IBM_ADDR_CTRL, 8'h00);
            if (r[b] === v) return;
        end
        mismatches++; end_of_test();
    endtask
    task automatic t_reset();
        apb(1'b0, `IBM_ADDR_CTRL, 8'h00); `CHK("ctrl reset", 32'h0000_0004, r)
        apb(1'b0, `IBM_ADDR_DATA, 8'h00); `CHK("data reset", 32'h0000_0000, r)
        apb(1'b0, 12'h394, 8'h00); `CHK("unmapped error", 1'b1, err)
        $display("test reset done");
    endtask
    task automatic t_write();
        apb(1'b1, `IBM_ADDR_IRQ_MASK, 8'h01); apb(1'b1, `IBM_ADDR_CTRL, 8'h82);
        apb(1'b1, `IBM_ADDR_CTRL, 8'h8a); wait_ctrl(3, 1'b0);
        apb(1'b1, `IBM_ADDR_DATA, 8'ha6); wait_ctrl(5, 1'b1);
        `CHK("tx ack", 1'b0, r[4])
        `CHK("tx byte", 8'ha6, rx[8:1])
        `CHK("scl period div64", 320, $rtoi(per))
        `CHK("irq set", 1'b1, irq_ff)
        apb(1'b1, `IBM_ADDR_CTRL, 8'h82); apb(1'b0, `IBM_ADDR_CTRL, 8'h00);
        `CHK("done cleared", 1'b0, r[5])
        apb(1'b0, `IBM_ADDR_IRQ_STAT, 8'h00); `CHK("status", 32'h0000_0001, r)
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq_ff)
        $display("test write done");
    endtask
    task automatic t_nack();
        nack = 1'b1; stretch = 1'b1;
        apb(1'b1, `IBM_ADDR_DATA, 8'h3c); wait_ctrl(5, 1'b1);
        `CHK("tx nack", 1'b1, r[4])
        `CHK("stretched byte", 8'h3c, rx[8:1])
        apb(1'b0, `IBM_ADDR_IRQ_STAT, 8'h00); `CHK("nack status", 32'h0000_0003, r)
        apb(1'b1, `IBM_ADDR_CTRL, 8'h82);
        nack = 1'b0; stretch = 1'b0;
        $display("test nack done");
    endtask
    task automatic t_read();
        rd_byte = 8'h5c; rd = 1'b1;
        apb(1'b1, `IBM_ADDR_CTRL, 8'h83); apb(1'b0, `IBM_ADDR_DATA, 8'h00); wait_ctrl(5, 1'b1);
        `CHK("rx ack sent", 1'b0, rx[0])
        `CHK("scl period div256", 1280, $rtoi(per))
        rd_byte = 8'hc3;
        apb(1'b1, `IBM_ADDR_CTRL, 8'hc3); apb(1'b0, `IBM_ADDR_DATA, 8'h00);
        `CHK("rx byte one", 32'h0000_005c, r)
        wait_ctrl(5, 1'b1); `CHK("rx nack sent", 1'b1, rx[0])
        rd = 1'b0;
        apb(1'b1, `IBM_ADDR_CTRL, 8'hc7); wait_ctrl(5, 1'b0);
        for (int n = 0; n < 2000 && (scl_oe_ff | sda_oe_ff) !== 1'b0; n++) @(posedge pclk);
        if ((scl_oe_ff | sda_oe_ff) !== 1'b0) begin mismatches++; end_of_test(); end
        `CHK("lines idle after stop", 2'b11, {scl, sda})
        apb(1'b0, `IBM_ADDR_DATA, 8'h00); `CHK("rx byte two", 32'h0000_00c3, r)
        apb(1'b0, `IBM_ADDR_CTRL, 8'h00); `CHK("stop bit", 1'b1, r[2])
        $display("test read done");
    endtask
    task automatic t_disable();
        apb(1'b1, `IBM_ADDR_CTRL, 8'h8b); wait_ctrl(3, 1'b0);
        apb(1'b1, `IBM_ADDR_DATA, 8'h00);
        repeat (100) @(posedge pclk);
        apb(1'b1, `IBM_ADDR_CTRL, 8'h00);
        repeat (3) @(posedge pclk);
        `CHK("released on disable", 2'b00, {scl_oe_ff, sda_oe_ff})
        $display("test disable done");
    endtask
    // Main sequence: reset for six cycles, then each scenario in turn
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_write();
        t_nack();
        t_read();
        t_disable();
        end_of_test();
    end
endmodule // ibm_master_test
